// >>> tb/bus_ctrl_model.sv
// Behavioural bus controller: sources commands and data, and listens to the device.
module bus_ctrl_model (
  input  wire logic       clk_in,
  input  wire logic [7:0] dio_w,
  input  wire logic       eoi_w,
  input  wire logic       dav_w,
  input  wire logic       nrfd_w,
  input  wire logic       ndac_w,
  output logic      [7:0] dio_n,
  output logic            atn_n,
  output logic            eoi_n,
  output logic            dav_n,
  output logic            nrfd_n,
  output logic            ndac_n,
  output logic            hang
);
  timeunit 1ns;
  timeprecision 1ns;
  int slow = 0;  // Extra cycles per wait, so the model can act as a slow party.

  // ----------------------------------------------------------------
  // Handshake tasks
  // ----------------------------------------------------------------
  // All lines start released; the pull-ups make them read high.
  initial begin
    {dio_n, atn_n, eoi_n, dav_n, nrfd_n, ndac_n, hang} = {8'hFF, 5'h1F, 1'b0};
  end

  // Every change lands just after a rising edge.
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clk_in);
      #1;
    end
  endtask

  // Source one byte; ATN selects command or data meaning.
  task automatic send(input logic atn, input logic [7:0] b, input logic eoi);
    int t;
    t = 0;
    tick(1);
    if (atn_n != !atn) begin
      atn_n = !atn;
      tick(3 + slow);
    end
    dio_n = ~b;
    eoi_n = !eoi;
    while (!(nrfd_w && !ndac_w) && t < 500) begin
      tick(1);
      t++;
    end
    tick(slow);
    dav_n = 1'b0;
    while (!ndac_w && t < 1000) begin
      tick(1);
      t++;
    end
    tick(slow);
    {dio_n, eoi_n, dav_n} = {8'hFF, 2'b11};
    if (t >= 1000) hang = 1'b1;
  endtask

  // Accept one byte from the device as listener.
  task automatic take(output logic [7:0] b, output logic e);
    int t;
    t = 0;
    ndac_n = 1'b0;
    tick(slow);
    while (dav_w && t < 500) begin
      tick(1);
      t++;
    end
    nrfd_n = 1'b0;
    b = ~dio_w;
    e = !eoi_w;
    tick(1 + slow);
    ndac_n = 1'b1;
    while (!dav_w && t < 1000) begin
      tick(1);
      t++;
    end
    ndac_n = 1'b0;
    tick(1);
    nrfd_n = 1'b1;
    if (t >= 1000) hang = 1'b1;
  endtask
endmodule

// >>> tb/testbench.sv
// Self-checking bench for the device-side instrument bus interface.
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed { logic [7:0] code; logic lis; logic tlk; } row_t;
  logic       clk_in, sys_rst_in, ifc_n_in, ren_n_in, rx_ready_in, tx_end_in, tx_valid_in;
  logic       srq_set_in, srq_clear_in, rcv_end;
  logic [4:0] prim_addr_in;
  logic [7:0] tx_data_in, rcv_byte;
  wire  [7:0] dio_n_in, dio_n_out, dio_oe_out, rx_data_out, bus_dio;
  wire        atn_n_in, eoi_n_in, dav_n_in, nrfd_n_in, ndac_n_in, eoi_n_out, eoi_oe_out;
  wire        srq_n_out, srq_oe_out, dav_n_out, dav_oe_out, nrfd_n_out, nrfd_oe_out;
  wire        ndac_n_out, ndac_oe_out, rx_end_out, rx_valid_out, tx_ready_out, listen_out;
  wire        talk_out, remote_out, lockout_out, dev_clear_out, bus_eoi, bus_dav, bus_nrfd;
  wire        bus_ndac, hang;
  int         err_total = 0, n_checks = 0, n_rx = 0, n_clr = 0, cyc = 0;
  // Primary address 16h: listen 36h, talk 56h.
  row_t       rows [9] = '{
    '{8'h36, 1'b1, 1'b0}, '{8'h76, 1'b1, 1'b0}, '{8'h56, 1'b1, 1'b1},
    '{8'h2A, 1'b1, 1'b1}, '{8'h3F, 1'b0, 1'b1}, '{8'h5F, 1'b0, 1'b0},
    '{8'hB6, 1'b1, 1'b0}, '{8'h56, 1'b1, 1'b1}, '{8'h45, 1'b1, 1'b0}};

  // Open-drain wires: a line is low when any party pulls it low.
  assign dio_n_in  = bus_dio & (dio_n_out | ~dio_oe_out);
  assign eoi_n_in  = bus_eoi & (eoi_n_out | ~eoi_oe_out);
  assign dav_n_in  = bus_dav & (dav_n_out | ~dav_oe_out);
  assign nrfd_n_in = bus_nrfd & (nrfd_n_out | ~nrfd_oe_out);
  assign ndac_n_in = bus_ndac & (ndac_n_out | ~ndac_oe_out);

  gpib_device_if dut (
    .clk_in, .sys_rst_in, .prim_addr_in, .dio_n_in, .dio_n_out, .dio_oe_out, .atn_n_in,
    .ifc_n_in, .ren_n_in, .eoi_n_in, .eoi_n_out, .eoi_oe_out, .srq_n_out, .srq_oe_out,
    .dav_n_in, .dav_n_out, .dav_oe_out, .nrfd_n_in, .nrfd_n_out, .nrfd_oe_out, .ndac_n_in,
    .ndac_n_out, .ndac_oe_out, .rx_ready_in, .rx_data_out, .rx_end_out, .rx_valid_out,
    .tx_data_in, .tx_end_in, .tx_valid_in, .tx_ready_out, .srq_set_in, .srq_clear_in,
    .listen_out, .talk_out, .remote_out, .lockout_out, .dev_clear_out
  );

  bus_ctrl_model bus (
    .clk_in, .dio_w(dio_n_in), .eoi_w(eoi_n_in), .dav_w(dav_n_in), .nrfd_w(nrfd_n_in),
    .ndac_w(ndac_n_in), .dio_n(bus_dio), .atn_n(atn_n_in), .eoi_n(bus_eoi), .dav_n(bus_dav),
    .nrfd_n(bus_nrfd), .ndac_n(bus_ndac), .hang(hang)
  );

  // ----------------------------------------------------------------
  // Clock, monitors and shared tasks
  // ----------------------------------------------------------------
  // The 20 MHz clock.
  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end

  // Pulse counters, and a cycle ceiling so that a hang still ends the run.
  always @(posedge clk_in) begin
    cyc++;
    if (rx_valid_out === 1'b1) n_rx++;
    if (dev_clear_out === 1'b1) n_clr++;
    if (cyc == 20000) begin
      err_total++;
      print_verdict();
    end
  end

  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clk_in);
      #1;
    end
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  // Hand one byte to the source side once it is ready.
  task automatic push(input logic [7:0] b, input logic e);
    int t;
    t = 0;
    while (tx_ready_out !== 1'b1 && t < 200) begin
      tick(1);
      t++;
    end
    {tx_data_in, tx_end_in, tx_valid_in} = {b, e, 1'b1};
    tick(1);
    tx_valid_in = 1'b0;
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {sys_rst_in, ifc_n_in, ren_n_in, rx_ready_in, tx_end_in, tx_valid_in} = 6'b111100;
    {srq_set_in, srq_clear_in, prim_addr_in, tx_data_in} = {2'b00, 5'h16, 8'h00};
    repeat (2) @(posedge clk_in);
    #1 sys_rst_in = 1'b0;
    tick(2);
    chk(dio_oe_out, 8'h00, "data lines released");
    chk({4'h0, dav_oe_out, nrfd_oe_out, srq_oe_out, listen_out}, 8'h00, "idle");
    $display("test reset done");
    foreach (rows[i]) begin
      bus.send(1'b1, rows[i].code, 1'b0);
      tick(2);
      chk(8'(listen_out), 8'(rows[i].lis), "listen role");
      chk(8'(talk_out), 8'(rows[i].tlk), "talk role");
    end
    $display("test addressing table done");
    bus.send(1'b0, 8'hA5, 1'b1);
    // The monitor counts the pulse one edge after the byte is taken.
    tick(1);
    chk(8'(n_rx), 8'h01, "data pulses");
    chk(rx_data_out, 8'hA5, "data byte");
    chk(8'(rx_end_out), 8'h01, "end flag");
    rx_ready_in = 1'b0;
    // The controller waits on NRFD, so the user side is freed from a parallel branch.
    fork
      bus.send(1'b0, 8'h5A, 1'b0);
      begin
        tick(10);
        chk(8'(nrfd_n_in), 8'h00, "not ready held");
        chk(dio_oe_out, 8'h00, "listener drives no data");
        rx_ready_in = 1'b1;
      end
    join
    bus.slow = 2;
    bus.send(1'b0, 8'h11, 1'b0);
    bus.slow = 0;
    chk(8'(n_rx), 8'h03, "data pulses");
    chk({rx_data_out[6:0], rx_end_out}, 8'h22, "last byte");
    $display("test listener data done");
    bus.send(1'b1, 8'h3F, 1'b0);
    bus.send(1'b1, 8'h56, 1'b0);
    bus.atn_n = 1'b1;
    tick(4);
    chk(dio_oe_out, 8'h00, "talker without a byte");
    push(8'h3C, 1'b0);
    tick(6);
    chk(8'(dav_n_in), 8'h01, "valid held off");
    chk(dio_oe_out, 8'hFF, "data driven");
    bus.take(rcv_byte, rcv_end);
    chk({rcv_byte[6:0], rcv_end}, 8'h78, "first byte");
    bus.slow = 2;
    fork
      push(8'hC3, 1'b1);
      bus.take(rcv_byte, rcv_end);
    join
    bus.slow = 0;
    chk(rcv_byte, 8'hC3, "second byte");
    chk(8'(rcv_end), 8'h01, "end marked");
    bus.ndac_n = 1'b1;
    bus.send(1'b1, 8'h5F, 1'b0);
    tick(2);
    chk(8'(talk_out), 8'h00, "untalk");
    $display("test talker done");
    bus.send(1'b1, 8'h36, 1'b0);
    bus.send(1'b1, 8'h56, 1'b0);
    ifc_n_in = 1'b0;
    tick(3);
    ifc_n_in = 1'b1;
    tick(3);
    chk({6'h00, listen_out, talk_out}, 8'h00, "interface clear");
    bus.send(1'b1, 8'h14, 1'b0);
    bus.send(1'b1, 8'h04, 1'b0);
    bus.send(1'b1, 8'h36, 1'b0);
    bus.send(1'b1, 8'h04, 1'b0);
    tick(2);
    chk(8'(n_clr), 8'h02, "device clears");
    $display("test clears done");
    ren_n_in = 1'b0;
    tick(4);
    chk(8'(remote_out), 8'h01, "remote");
    bus.send(1'b1, 8'h11, 1'b0);
    tick(2);
    chk(8'(lockout_out), 8'h01, "lockout");
    bus.send(1'b1, 8'h01, 1'b0);
    tick(2);
    chk(8'(remote_out), 8'h00, "go to local");
    ren_n_in = 1'b1;
    tick(4);
    chk(8'(lockout_out), 8'h00, "lockout ends");
    srq_set_in = 1'b1;
    tick(1);
    srq_set_in = 1'b0;
    tick(8);
    chk(8'(srq_oe_out), 8'h01, "service request held");
    srq_clear_in = 1'b1;
    tick(1);
    srq_clear_in = 1'b0;
    tick(2);
    chk(8'(srq_oe_out), 8'h00, "service request cleared");
    // A reset in mid-run must drop the roles taken on the bus.
    bus.send(1'b1, 8'h56, 1'b0);
    sys_rst_in = 1'b1;
    tick(2);
    sys_rst_in = 1'b0;
    tick(2);
    chk({6'h00, listen_out, talk_out}, 8'h00, "roles after reset");
    chk(8'(hang), 8'h00, "handshakes completed");
    $display("test remote and service done");
    print_verdict();
  end
endmodule

// >>> verilog/gpib_device_if.sv
// Device-side instrument bus interface: addressing, handshake and uniline handling.
//
// Function
// - Bytes travel over eight bidirectional data lines, one per handshake.
// - All bus lines are low-true; released high means false.
// - Primary address 0 to 31 forms the talk and listen addresses.
// - Listen address is primary address OR 20h, taken under ATN.
// - Talk address is primary address OR 40h, taken under ATN.
// - Secondary addresses 60h-7Fh leave the addressed state untouched.
// - ATN true means command bytes; ATN false means device data.
// - One interlocked handshake serves data, addresses and commands alike.
// - Drive data only while addressed to talk; listeners may be many.
// - Only the source drives DAV to mark the byte valid.
// - Acceptor holds NRFD true until ready for the next byte.
// - Acceptor holds NDAC true until it has taken the byte.
// - Source asserts DAV only with NRFD high and NDAC low.
// - After ATN goes true, acceptor holds NRFD and NDAC stable 100 ns.
// - On DAV low, acceptor pulls NRFD low, then releases NDAC; this acceptor does both on one edge.
// - Source counts a byte accepted only when shared NDAC goes high.
// - Source then releases DAV; acceptors return NDAC low, release NRFD.
// - When talking, response bytes leave one by one as source.
// - EOI marks the last byte; detected as listener, driven as talker.
// - SRQ is asserted when service is needed and held until serviced.
// - REN true puts the device into remote operation.
// - IFC clears the bus interface state.
// - IFC returns the device to talker idle and listener idle.
// - DCL, or SDC while listening, restores default conditions.
// - GTL while listening returns to local; LLO locks out local control.
// - UNL drops listener role, UNT drops talker role, both under ATN.
// - UNL makes the device listener idle whatever its address.
module gpib_device_if
  import gpib_pkg::*;
(
  input  wire logic              clk_in,
  input  wire logic              sys_rst_in,
  input  wire logic [ADDR_W-1:0] prim_addr_in,
  input  wire logic [7:0]        dio_n_in,
  output logic      [7:0]        dio_n_out,
  output logic      [7:0]        dio_oe_out,
  input  wire logic              atn_n_in,
  input  wire logic              ifc_n_in,
  input  wire logic              ren_n_in,
  input  wire logic              eoi_n_in,
  output logic                   eoi_n_out,
  output logic                   eoi_oe_out,
  output logic                   srq_n_out,
  output logic                   srq_oe_out,
  input  wire logic              dav_n_in,
  output logic                   dav_n_out,
  output logic                   dav_oe_out,
  input  wire logic              nrfd_n_in,
  output logic                   nrfd_n_out,
  output logic                   nrfd_oe_out,
  input  wire logic              ndac_n_in,
  output logic                   ndac_n_out,
  output logic                   ndac_oe_out,
  input  wire logic              rx_ready_in,
  output logic      [7:0]        rx_data_out,
  output logic                   rx_end_out,
  output logic                   rx_valid_out,
  input  wire logic [7:0]        tx_data_in,
  input  wire logic              tx_end_in,
  input  wire logic              tx_valid_in,
  output logic                   tx_ready_out,
  input  wire logic              srq_set_in,
  input  wire logic              srq_clear_in,
  output logic                   listen_out,
  output logic                   talk_out,
  output logic                   remote_out,
  output logic                   lockout_out,
  output logic                   dev_clear_out
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [14:0] meta_r;
  logic [14:0] sync_r;

  // two-flop synchronisers.
  // Data lines share the flops with DAV; the source sets data up before DAV,
  // so data is settled by the time the synchronised DAV is seen.
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      meta_r <= SYNC_RST;
      sync_r <= SYNC_RST;
    end else begin
      meta_r <= {dio_n_in, atn_n_in, ifc_n_in, ren_n_in, eoi_n_in,
                 dav_n_in, nrfd_n_in, ndac_n_in};
      sync_r <= meta_r;
    end
  end

  logic [7:0] dio_s;
  logic       atn_s;
  logic       ifc_s;
  logic       ren_s;
  logic       eoi_s;
  logic       dav_s;
  logic       nrfd_s;
  logic       ndac_s;
  // low level on a line means true.
  assign dio_s  = ~sync_r[14:7];
  assign atn_s  = ~sync_r[6];
  assign ifc_s  = ~sync_r[5];
  assign ren_s  = ~sync_r[4];
  assign eoi_s  = ~sync_r[3];
  assign dav_s  = ~sync_r[2];
  assign nrfd_s = ~sync_r[1];
  assign ndac_s = ~sync_r[0];

  // ----------------------------------------------------------------
  // ATN settle hold
  // ----------------------------------------------------------------
  logic       atn_prev_r;
  logic [2:0] hold_cnt_r;
  logic       atn_rise;
  logic       hold_busy;
  assign atn_rise  = atn_s & ~atn_prev_r;
  assign hold_busy = atn_rise | (hold_cnt_r != 3'h0);
  // freeze the acceptor outputs for 100 ns after ATN goes true.
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      atn_prev_r <= 1'b0;
      hold_cnt_r <= 3'h0;
    end else begin
      atn_prev_r <= atn_s;
      if (atn_rise) begin
        hold_cnt_r <= ATN_HOLD_CYC;
      end else if (hold_cnt_r != 3'h0) begin
        hold_cnt_r <= hold_cnt_r - 3'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Acceptor handshake
  // ----------------------------------------------------------------
  acc_state_t acc_st_r;
  logic       listen_r;
  logic       talk_r;
  logic       acc_act;
  logic       take;
  // Under ATN every device takes part, addressed or not.
  assign acc_act = (atn_s | listen_r) & ~ifc_s;
  assign take    = (acc_st_r == ACC_READY) & dav_s & acc_act & ~hold_busy;
  // one interlocked sequence for all bytes.
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      acc_st_r <= ACC_IDLE;
    end else if (!acc_act) begin
      acc_st_r <= ACC_IDLE;
    end else if (!hold_busy) begin
      case (acc_st_r)
        ACC_IDLE:  acc_st_r <= ACC_HOLD;
        // NRFD held until ready and the previous DAV is gone.
        ACC_HOLD:  if ((atn_s | rx_ready_in) && !dav_s) begin
                     acc_st_r <= ACC_READY;
                   end
        // DAV seen, take the byte and swap NRFD for NDAC.
        ACC_READY: if (dav_s) begin
                     acc_st_r <= ACC_TAKEN;
                   end
        // DAV released, back to NDAC low and NRFD held.
        ACC_TAKEN: if (!dav_s) begin
                     acc_st_r <= ACC_HOLD;
                   end
        default:   acc_st_r <= ACC_IDLE;
      endcase
    end
  end

  // NDAC true until the byte is taken.
  assign nrfd_oe_out = (acc_st_r == ACC_HOLD) | (acc_st_r == ACC_TAKEN);
  assign ndac_oe_out = (acc_st_r == ACC_HOLD) | (acc_st_r == ACC_READY);
  assign nrfd_n_out  = 1'b0;
  assign ndac_n_out  = 1'b0;

  // data bytes reach the user only with ATN false.
  // EOI is latched with the byte it marks.
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      rx_data_out  <= 8'h00;
      rx_end_out   <= 1'b0;
      rx_valid_out <= 1'b0;
    end else begin
      rx_valid_out <= take & ~atn_s;
      if (take && !atn_s) begin
        rx_data_out <= dio_s;
        rx_end_out  <= eoi_s;
      end
    end
  end

  // ----------------------------------------------------------------
  // Command decode under ATN
  // ----------------------------------------------------------------
  logic       cmd_stb;
  logic [6:0] cmd;
  logic [6:0] my_listen;
  logic [6:0] my_talk;
  logic       ren_prev_r;
  // address is the full 5-bit switch value.
  assign my_listen = GRP_LISTEN | {2'b00, prim_addr_in};
  assign my_talk   = GRP_TALK | {2'b00, prim_addr_in};
  assign cmd_stb   = take & atn_s;
  assign cmd       = dio_s[6:0];

  // IFC drops both roles, ahead of any command.
  // UNL wins over a listen address that shares its code.
  // secondary group matches neither branch and is ignored.
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      listen_r <= 1'b0;
      talk_r   <= 1'b0;
    end else if (ifc_s) begin
      listen_r <= 1'b0;
      talk_r   <= 1'b0;
    end else if (cmd_stb) begin
      if (cmd == CMD_UNL) begin
        listen_r <= 1'b0;
      end else if (cmd == my_listen) begin
        listen_r <= 1'b1;
      end
      if (cmd == CMD_UNT) begin
        talk_r <= 1'b0;
      end else if (cmd == my_talk) begin
        talk_r <= 1'b1;
      end else if ((cmd & GRP_MASK) == GRP_TALK) begin
        // another talker addressed, only one may be active.
        talk_r <= 1'b0;
      end
    end
  end

  // device clear pulse, universal or selective while listening.
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      dev_clear_out <= 1'b0;
    end else begin
      dev_clear_out <= cmd_stb & ((cmd == CMD_DCL) | ((cmd == CMD_SDC) & listen_r));
    end
  end

  // REN going true enters remote; own listen address under REN also does.
  // GTL while listening returns to local; LLO locks out.
  // Lockout only lasts while REN is true, so dropping REN frees the panel.
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      ren_prev_r  <= 1'b0;
      remote_out  <= 1'b0;
      lockout_out <= 1'b0;
    end else begin
      ren_prev_r <= ren_s;
      if (!ren_s) begin
        remote_out  <= 1'b0;
        lockout_out <= 1'b0;
      end else begin
        if (cmd_stb && cmd == CMD_GTL && listen_r) begin
          remote_out <= 1'b0;
        end else if (!ren_prev_r || (cmd_stb && cmd == my_listen)) begin
          remote_out <= 1'b1;
        end
        if (cmd_stb && cmd == CMD_LLO) begin
          lockout_out <= 1'b1;
        end
      end
    end
  end

  assign listen_out = listen_r;
  assign talk_out   = talk_r;

  // ----------------------------------------------------------------
  // Source handshake
  // ----------------------------------------------------------------
  src_state_t src_st_r;
  logic [7:0] tx_byte_n_r;
  logic       tx_end_r;
  logic       src_act;
  logic       src_drive;

  // only an addressed talker with ATN false may source.
  assign src_act      = talk_r & ~atn_s & ~ifc_s;
  assign tx_ready_out = src_act & (src_st_r == SRC_IDLE);

  // response bytes leave one at a time.
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      src_st_r <= SRC_IDLE;
    end else if (!src_act) begin
      src_st_r <= SRC_IDLE;
    end else begin
      case (src_st_r)
        SRC_IDLE:  if (tx_valid_in) begin
                     src_st_r <= SRC_SETUP;
                   end
        // wait for all ready and NDAC low.
        SRC_SETUP: if (!nrfd_s && ndac_s) begin
                     src_st_r <= SRC_VALID;
                   end
        // accepted only once shared NDAC goes high.
        SRC_VALID: if (!ndac_s) begin
                     src_st_r <= SRC_DONE;
                   end
        // DAV and data removed for one cycle.
        SRC_DONE:  src_st_r <= SRC_IDLE;
        default:   src_st_r <= SRC_IDLE;
      endcase
    end
  end

  // Byte is held inverted so the pin value comes straight from a flop.
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      tx_byte_n_r <= 8'hFF;
      tx_end_r    <= 1'b0;
    end else if (tx_ready_out && tx_valid_in) begin
      tx_byte_n_r <= ~tx_data_in;
      tx_end_r    <= tx_end_in;
    end
  end

  assign src_drive = src_act & ((src_st_r == SRC_SETUP) | (src_st_r == SRC_VALID));
  // data lines driven as a byte.
  assign dio_n_out  = tx_byte_n_r;
  assign dio_oe_out = {8{src_drive}};
  // EOI driven alongside the last byte.
  assign eoi_n_out  = 1'b0;
  assign eoi_oe_out = src_drive & tx_end_r;
  // DAV driven only by this end as source.
  assign dav_n_out  = 1'b0;
  assign dav_oe_out = src_act & (src_st_r == SRC_VALID);

  // ----------------------------------------------------------------
  // Service request
  // ----------------------------------------------------------------
  logic srq_r;
  // request held until serviced; a new request wins over a clear.
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      srq_r <= 1'b0;
    end else if (srq_set_in) begin
      srq_r <= 1'b1;
    end else if (srq_clear_in || dev_clear_out) begin
      srq_r <= 1'b0;
    end
  end
  assign srq_n_out  = 1'b0;
  assign srq_oe_out = srq_r;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);

  a_no_drive_idle: assert property (!talk_r |-> dio_oe_out == 8'h00)
    else $error("data lines driven while not addressed to talk");
  a_dav_ready_gate: assert property ($rose(dav_oe_out) |-> $past(!nrfd_s && ndac_s))
    else $error("DAV asserted before NRFD high and NDAC low");
  a_dav_until_ndac: assert property (dav_oe_out && ndac_s && src_act |=> dav_oe_out)
    else $error("DAV released before NDAC went high");
  a_listen_addr: assert property (cmd_stb && !ifc_s && cmd == my_listen && cmd != CMD_UNL
                                  |=> listen_r)
    else $error("own listen address not taken");
  // At address 31 the own talk code is the untalk code, and untalk wins.
  a_talk_addr: assert property (cmd_stb && !ifc_s && cmd == my_talk && cmd != CMD_UNT
                                |=> talk_r ##1 1'b1)
    else $error("own talk address not taken");
  a_secondary_ignored: assert property (cmd_stb && !ifc_s && (cmd & GRP_MASK) == GRP_SECONDARY
                                        |=> $stable(listen_r) && $stable(talk_r))
    else $error("secondary address changed addressed state");
  a_ifc_clears: assert property (ifc_s |=> !listen_r && !talk_r && !dav_oe_out)
    else $error("IFC did not return device to idle");
  a_unl_idle: assert property (cmd_stb && !ifc_s && cmd == CMD_UNL |=> !listen_r)
    else $error("UNL did not clear listener state");
  a_atn_hold: assert property (atn_rise |=> $stable(nrfd_oe_out) && $stable(ndac_oe_out)
                               ##1 $stable(nrfd_oe_out) && $stable(ndac_oe_out))
    else $error("NRFD or NDAC changed within 100 ns of ATN");
  a_srq_held: assert property (srq_oe_out && !srq_clear_in && !dev_clear_out
                               |=> srq_oe_out)
    else $error("SRQ dropped before being serviced");
  a_dev_clear: assert property (cmd_stb && cmd == CMD_DCL |=> dev_clear_out)
    else $error("DCL did not pulse device clear");

  c_listen: cover property (cmd_stb && cmd == my_listen ##[1:50] rx_valid_out);
  c_talk_end: cover property (eoi_oe_out && dav_oe_out);
  c_sdc: cover property (cmd_stb && cmd == CMD_SDC && listen_r);
  c_lockout: cover property ($rose(lockout_out));

endmodule

// >>> verilog/gpib_pkg.sv
// Constants and state types shared by the instrument bus interface.
package gpib_pkg;

  // ----------------------------------------------------------------
  // Multiline command codes (7 bits, DIO8 ignored)
  // ----------------------------------------------------------------
  localparam logic [6:0] CMD_GTL       = 7'h01;
  localparam logic [6:0] CMD_SDC       = 7'h04;
  localparam logic [6:0] CMD_LLO       = 7'h11;
  localparam logic [6:0] CMD_DCL       = 7'h14;
  localparam logic [6:0] CMD_UNL       = 7'h3F;
  localparam logic [6:0] CMD_UNT       = 7'h5F;
  localparam logic [6:0] GRP_LISTEN    = 7'h20;
  localparam logic [6:0] GRP_TALK      = 7'h40;
  localparam logic [6:0] GRP_SECONDARY = 7'h60;
  localparam logic [6:0] GRP_MASK      = 7'h60;

  // ----------------------------------------------------------------
  // Primary address range
  // ----------------------------------------------------------------
  localparam int         ADDR_W   = 5;
  localparam logic [4:0] ADDR_MAX = 5'h1F;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int         CLK_PERIOD_NS = 50;
  localparam int         ATN_HOLD_NS   = 100;
  localparam int         ATN_HOLD_INT  = (ATN_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [2:0] ATN_HOLD_CYC  = 3'(ATN_HOLD_INT);

  // ----------------------------------------------------------------
  // Reset values and state types
  // ----------------------------------------------------------------
  localparam logic [14:0] SYNC_RST = 15'h7FFF;  // All bus lines released (high).

  typedef enum logic [1:0] {
    ACC_IDLE  = 2'b00,
    ACC_HOLD  = 2'b01,
    ACC_READY = 2'b10,
    ACC_TAKEN = 2'b11
  } acc_state_t;

  typedef enum logic [1:0] {
    SRC_IDLE  = 2'b00,
    SRC_SETUP = 2'b01,
    SRC_VALID = 2'b10,
    SRC_DONE  = 2'b11
  } src_state_t;

endpackage
